// >>> design/etc_ctrl.v
// How it works
// - the block only acts while test mode enable (pin or software bit) is high; here regulator off follows burn-in select whatever the enable.
// - two modes exist, tester-driven direct access and built-in pattern generation.
// - the control and address port is 16 bits and data may be 8, 16 or 32 bits.
// - a 16-bit data build uses 32 tester signals, a 32-bit build uses 48.
// - the tester sends 4-bit commands, 8-bit addresses, its clock and a low reset.
// - one two-way tester data bus carries data in and out, turned by pad direction.
// - burn-in select and march start come from custom logic, march start tied low if unused.
// - the march starts when enable and reset rise while the pattern-run command is held; here march start (pin or software bit) must be high too.
// - the march stops when enable drops, reset drops or pattern-run is removed.
// - the march visits every normal DRAM word in turn.
// - four passes: write 0, read 0 write 1, read 1 write 0, read 0, rippling address.
// - burn-in turns the regulator off and latches fail, otherwise fail is combinational.
// - a latched fail clears on a burn-in toggle or a reset.
// - no refresh runs, so the tester clock must stay at or above 4 MHz.
// - during the march tester address, data and direction are ignored.
//
// Design decisions made here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "etc_map.vh"
module etc_ctrl #(
   parameter DW = 16,
   parameter AW = 16
) (
   input  wire          aclk,
   input  wire          aresetn,
   input  wire [7:0]    s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [7:0]    s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   output wire          irq,
   input  wire          test_mode_enable,
   input  wire          burn_in_select,
   input  wire          march_start,
   input  wire          controller_clock,
   input  wire          controller_reset_n,
   input  wire [3:0]    tester_command_bus,
   input  wire [7:0]    tester_address_bus,
   input  wire          pad_direction_select,
   input  wire [DW-1:0] tester_data_in,
   output reg  [DW-1:0] tester_data_out,
   output wire          tester_data_oe,
   output wire          fail_flag,
   output reg           dram_en,
   output reg           dram_we,
   output reg  [AW-1:0] dram_addr,
   output reg  [DW-1:0] dram_wdata,
   input  wire [DW-1:0] dram_rdata,
   output wire          regulator_off
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // every tester pin is resynchronised as one group, data included
   localparam SW = 18 + DW;
   reg  [SW-1:0] sy1;
   reg  [SW-1:0] sy2;
   reg           tck_d;
   always @(posedge aclk) begin
      if (!aresetn) begin
         sy1   <= {SW{1'b0}};
         sy2   <= {SW{1'b0}};
         tck_d <= 1'b0;
      end else begin
         sy1   <= {tester_data_in, pad_direction_select, tester_address_bus,
                   tester_command_bus, controller_reset_n, controller_clock,
                   march_start, burn_in_select, test_mode_enable};
         sy2   <= sy1;
         tck_d <= sy2[3];
      end
   end
   wire          test_s  = sy2[0];
   wire          burn_s  = sy2[1];
   wire          march_s = sy2[2];
   wire          tck_s   = sy2[3];
   wire          rstn_s  = sy2[4];
   wire [3:0]    cmd_s   = sy2[8:5];
   wire [7:0]    adr_s   = sy2[16:9];
   wire          ddir_s  = sy2[17];
   wire [DW-1:0] din_s   = sy2[SW-1:18];
   // edge found between settled stages, never from the first one
   wire          tck_rise = tck_s & ~tck_d;
   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   reg  [1:0]            ctrl;
   reg  [`ETC_IRQ_W-1:0] irq_stat;
   reg  [`ETC_IRQ_W-1:0] irq_en;
   reg  [`ETC_IRQ_W-1:0] irq_set;
   reg  [`ETC_IRQ_W-1:0] irq_clr;
   // software bits stand in for the test mode enable and march start pins when those are not bonded
   wire active = test_s | ctrl[`ETC_CTRL_TEST];
   wire go     = active & rstn_s;
   wire mstart = march_s | ctrl[`ETC_CTRL_MARCH];
   // ---------------------------------------------------------------
   // march and direct access state
   // ---------------------------------------------------------------
   reg           go_d;
   reg           run;
   reg           done;
   reg  [1:0]    phase;
   reg           sub;
   reg  [AW-1:0] maddr;
   reg           rd_pend;
   reg           rd_march;
   reg           exp_one;
   reg           burn_d;
   reg           fail_lat;
   reg  [5:0]    gap;
   // entry needs a rising go, so holding go high never restarts a finished walk
   wire          is_pg   = (cmd_s == `ETC_CMD_PG_RUN);
   wire          m_enter = go & ~go_d & is_pg & mstart;
   wire          m_stop  = run & (~go | ~is_pg);
   wire          last_a  = (maddr == {AW{1'b1}});
   wire          mismatch = rd_pend & rd_march &
                            (dram_rdata != {DW{exp_one}});
   // both element halves done when the second op of a two-op pass or any op of the others
   wire          elem_end = (phase == 2'd0) | (phase == 2'd3) | sub;
   wire          slow    = run & ~done & (gap > `ETC_TCK_GAP_MAX);
   // ---------------------------------------------------------------
   // march sequencer and direct access
   // ---------------------------------------------------------------
   // the tester clock paces the walk, so a slow tester stretches the refresh gap
   always @(posedge aclk) begin
      if (!aresetn) begin
         go_d       <= 1'b0;
         run        <= 1'b0;
         done       <= 1'b0;
         phase      <= 2'd0;
         sub        <= 1'b0;
         maddr      <= {AW{1'b0}};
         rd_pend    <= 1'b0;
         rd_march   <= 1'b0;
         exp_one    <= 1'b0;
         dram_en    <= 1'b0;
         dram_we    <= 1'b0;
         dram_addr  <= {AW{1'b0}};
         dram_wdata <= {DW{1'b0}};
         tester_data_out <= {DW{1'b0}};
         gap        <= 6'h00;
      end else begin
         go_d     <= go;
         dram_en  <= 1'b0;
         dram_we  <= 1'b0;
         rd_pend  <= dram_en & ~dram_we;
         rd_march <= run;
         if (rd_pend & ~rd_march)
            tester_data_out <= dram_rdata;
         if (~run | tck_rise)
            gap <= 6'h00;
         // saturate so a stopped tester clock never wraps back to a legal gap
         else if (gap != 6'h3F)
            gap <= gap + 6'h01;
         if (m_enter) begin
            run   <= 1'b1;
            done  <= 1'b0;
            phase <= 2'd0;
            sub   <= 1'b0;
            maddr <= {AW{1'b0}};
         end else if (m_stop) begin
            run <= 1'b0;
         end else if (run & ~done & tck_rise) begin
            // one access per tester clock, address and data inputs unused
            dram_en   <= 1'b1;
            dram_addr <= maddr;
            case (phase)
               2'd0: begin
                  dram_we    <= 1'b1;
                  dram_wdata <= {DW{1'b0}};
               end
               2'd1: begin
                  dram_we    <= sub;
                  dram_wdata <= {DW{1'b1}};
                  exp_one    <= 1'b0;
               end
               2'd2: begin
                  dram_we    <= sub;
                  dram_wdata <= {DW{1'b0}};
                  exp_one    <= 1'b1;
               end
               default: begin
                  dram_we <= 1'b0;
                  exp_one <= 1'b0;
               end
            endcase
            // sub selects the read or the write half of a two-op element
            sub <= (phase == 2'd1 || phase == 2'd2) ? ~sub : 1'b0;
            if (elem_end) begin
               maddr <= maddr + {{(AW-1){1'b0}}, 1'b1};
               if (last_a) begin
                  // done parks the walk until go falls and rises again
                  if (phase == 2'd3)
                     done <= 1'b1;
                  else
                     phase <= phase + 2'd1;
               end
            end
         end else if (~run & go & tck_rise) begin
            // direct access from the tester command bus
            if (cmd_s == `ETC_CMD_LD_ROW)
               dram_addr[AW-1:8] <= adr_s[AW-9:0];
            else if (cmd_s == `ETC_CMD_LD_COL)
               dram_addr[7:0] <= adr_s;
            else if (cmd_s == `ETC_CMD_WRITE) begin
               dram_en    <= 1'b1;
               dram_we    <= 1'b1;
               dram_wdata <= din_s;
            end else if (cmd_s == `ETC_CMD_READ)
               dram_en <= 1'b1;
         end
      end
   end
   // ---------------------------------------------------------------
   // fail reporting and burn-in
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         burn_d   <= 1'b0;
         fail_lat <= 1'b0;
      end else begin
         burn_d <= burn_s;
         // a fail in the clearing cycle is kept rather than lost
         if (burn_s & mismatch)
            fail_lat <= 1'b1;
         else if ((burn_s != burn_d) | ~rstn_s)
            fail_lat <= 1'b0;
      end
   end
   assign fail_flag     = burn_s ? fail_lat : mismatch;
   assign regulator_off = burn_s;
   // the pad only drives toward the tester outside the march
   assign tester_data_oe = go & ~run & ddir_s;
   // ---------------------------------------------------------------
   // axi4-lite slave
   // ---------------------------------------------------------------
   reg        aw_got;
   reg        w_got;
   reg  [7:0] aw_q;
   reg [31:0] w_q;
   reg  [3:0] ws_q;
   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   wire       aw_now = aw_got | s_axi_awvalid;
   wire       w_now  = w_got | s_axi_wvalid;
   wire [7:0] waddr  = aw_got ? aw_q : s_axi_awaddr;
   wire [31:0] wdat  = w_got ? w_q : s_axi_wdata;
   wire [3:0] wstb   = w_got ? ws_q : s_axi_wstrb;
   wire       do_wr  = aw_now & w_now & ~s_axi_bvalid;
   // ---------------------------------------------------------------
   // interrupt sources
   // ---------------------------------------------------------------
   // abort is only flagged for a walk cut before its last read
   always @* begin
      irq_set = {`ETC_IRQ_W{1'b0}};
      irq_set[`ETC_IRQ_DONE]  = run & ~done & tck_rise & elem_end &
                                last_a & (phase == 2'd3) & ~m_stop;
      irq_set[`ETC_IRQ_FAIL]  = mismatch;
      irq_set[`ETC_IRQ_ABORT] = m_stop & ~done;
      irq_set[`ETC_IRQ_SLOW]  = slow;
      irq_clr = {`ETC_IRQ_W{1'b0}};
      if (do_wr & (waddr == `ETC_REG_IRQ_CLR) & wstb[0])
         irq_clr = wdat[`ETC_IRQ_W-1:0];
   end
   // ---------------------------------------------------------------
   // write channel and register file
   // ---------------------------------------------------------------
   // address and data may arrive in either order, each is parked until both stand
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got       <= 1'b0;
         w_got        <= 1'b0;
         aw_q         <= 8'h00;
         w_q          <= 32'h00000000;
         ws_q         <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `ETC_RESP_OKAY;
         ctrl         <= `ETC_CTRL_RST;
         irq_en       <= `ETC_IRQ_EN_RST;
         irq_stat     <= {`ETC_IRQ_W{1'b0}};
      end else begin
         // a new event wins over a clear in the same cycle
         irq_stat <= (irq_stat & ~irq_clr) | irq_set;
         if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (do_wr) begin
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `ETC_RESP_OKAY;
            if (waddr == `ETC_REG_CTRL) begin
               if (wstb[0])
                  ctrl <= wdat[1:0];
            end else if (waddr == `ETC_REG_IRQ_EN) begin
               if (wstb[0])
                  irq_en <= wdat[`ETC_IRQ_W-1:0];
            end else if (waddr == `ETC_REG_IRQ_CLR) begin
               s_axi_bresp <= `ETC_RESP_OKAY;
            // writes to read-only registers are accepted and dropped
            end else if (waddr == `ETC_REG_STATUS || waddr == `ETC_REG_IRQ_STAT ||
                         waddr == `ETC_REG_MADDR) begin
               s_axi_bresp <= `ETC_RESP_OKAY;
            end else begin
               s_axi_bresp <= `ETC_RESP_SLVERR;
            end
         end else begin
            if (s_axi_awvalid & s_axi_awready) begin
               aw_got <= 1'b1;
               aw_q   <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
               w_got <= 1'b1;
               w_q   <= s_axi_wdata;
               ws_q  <= s_axi_wstrb;
            end
         end
      end
   end
   // ---------------------------------------------------------------
   // read channel
   // ---------------------------------------------------------------
   // the read mux is registered, so every answer waits one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= `ETC_RESP_OKAY;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end else if (s_axi_arvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= `ETC_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
         if (s_axi_araddr == `ETC_REG_CTRL)
            s_axi_rdata[1:0] <= ctrl;
         // status order from bit 0: run, done, fail, active, phase, burn
         else if (s_axi_araddr == `ETC_REG_STATUS)
            s_axi_rdata[6:0] <= {burn_s, phase, active, fail_lat, done, run};
         else if (s_axi_araddr == `ETC_REG_IRQ_STAT)
            s_axi_rdata[`ETC_IRQ_W-1:0] <= irq_stat;
         else if (s_axi_araddr == `ETC_REG_IRQ_EN)
            s_axi_rdata[`ETC_IRQ_W-1:0] <= irq_en;
         else if (s_axi_araddr == `ETC_REG_IRQ_CLR)
            s_axi_rdata <= 32'h00000000;
         else if (s_axi_araddr == `ETC_REG_MADDR)
            s_axi_rdata[AW-1:0] <= maddr;
         else
            s_axi_rresp <= `ETC_RESP_SLVERR;
      end
   end
   // ---------------------------------------------------------------
   // interrupt output
   // ---------------------------------------------------------------
   assign irq = |(irq_stat & irq_en);
endmodule // etc_ctrl
`default_nettype wire

// >>> design/etc_map.vh
`ifndef ETC_MAP_VH
`define ETC_MAP_VH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ETC_REG_CTRL      8'h00
`define ETC_REG_STATUS    8'h04
`define ETC_REG_IRQ_STAT  8'h08
`define ETC_REG_IRQ_EN    8'h0C
`define ETC_REG_IRQ_CLR   8'h10
`define ETC_REG_MADDR     8'h14
// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define ETC_CTRL_TEST     0
`define ETC_CTRL_MARCH    1
`define ETC_CTRL_RST      2'h0
`define ETC_IRQ_DONE      0
`define ETC_IRQ_FAIL      1
`define ETC_IRQ_ABORT     2
`define ETC_IRQ_SLOW      3
`define ETC_IRQ_W         4
`define ETC_IRQ_EN_RST    4'h0
// ---------------------------------------------------------------
// tester command codes
// ---------------------------------------------------------------
`define ETC_CMD_NOP       4'h0
`define ETC_CMD_LD_ROW    4'h1
`define ETC_CMD_LD_COL    4'h2
`define ETC_CMD_WRITE     4'h3
`define ETC_CMD_READ      4'h4
`define ETC_CMD_PG_RUN    4'h5
// ---------------------------------------------------------------
// bus responses and timing
// ---------------------------------------------------------------
`define ETC_RESP_OKAY     2'h0
`define ETC_RESP_SLVERR   2'h2
`define ETC_ACLK_KHZ      125000
`define ETC_TCK_MIN_KHZ   4000
`define ETC_TCK_GAP_MAX   (`ETC_ACLK_KHZ / `ETC_TCK_MIN_KHZ)
`endif

// >>> testbench/etc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module etc_ctrl_props #(
   parameter DW = 16,
   parameter AW = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_arready,
   input wire logic pad_direction_select,
   input wire logic tester_data_oe,
   input wire logic burn_in_select,
   input wire logic controller_reset_n,
   input wire logic fail_flag,
   input wire logic dram_en,
   input wire logic dram_we,
   input wire logic regulator_off
);
   // ------------------------------------------
   // pin, DRAM strobe and read channel checks in the system clock domain
   // ------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // five samples cover the two-stage synchroniser plus the clear cycle
   sequence s_burn_steady; (burn_in_select && controller_reset_n)[*5]; endsequence
   sequence s_burn_low; (!burn_in_select)[*5]; endsequence
   property p_oe_dir; tester_data_oe |-> $past(pad_direction_select, 2); endproperty
   a_oe_dir: assert property (p_oe_dir) else $error("pad driven against direction");
   property p_reg_off; 1'b1 |-> regulator_off == $past(burn_in_select, 2); endproperty
   a_reg_off: assert property (p_reg_off) else $error("regulator off wrong");
   property p_en_pulse; dram_en |=> !dram_en; endproperty
   a_en_pulse: assert property (p_en_pulse) else $error("access not single cycle");
   property p_we_en; dram_we |-> dram_en; endproperty
   a_we_en: assert property (p_we_en) else $error("write strobe without enable");
   property p_reset_idle; (!controller_reset_n)[*5] |-> !dram_en; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("access in reset");
   property p_fail_hold; s_burn_steady ##0 $past(fail_flag) |-> fail_flag; endproperty
   a_fail_hold: assert property (p_fail_hold) else $error("latched fail lost");
   property p_fail_toggle; $changed(burn_in_select) |-> ##[1:5] !fail_flag; endproperty
   a_fail_toggle: assert property (p_fail_toggle) else $error("fail kept on toggle");
   property p_fail_rst; $fell(controller_reset_n) |-> ##[1:5] !fail_flag; endproperty
   a_fail_rst: assert property (p_fail_rst) else $error("fail kept on reset");
   property p_fail_pulse; s_burn_low ##0 fail_flag |=> !fail_flag; endproperty
   a_fail_pulse: assert property (p_fail_pulse) else $error("fail held without burn");
   property p_rd_refuse; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("read taken while answering");
   property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read answer dropped");
endmodule // etc_ctrl_props
bind etc_ctrl etc_ctrl_props #(.DW(DW), .AW(AW)) u_props (
   .aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_arready, .pad_direction_select,
   .tester_data_oe, .burn_in_select, .controller_reset_n, .fail_flag, .dram_en, .dram_we,
   .regulator_off);
`default_nettype wire

// >>> testbench/etc_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module etc_dram_model #(
   parameter DW       = 16,
   parameter AW       = 9,
   parameter BAD_ADDR = 5
) (
   input  wire logic          aclk,
   input  wire logic          dram_en,
   input  wire logic          dram_we,
   input  wire logic [AW-1:0] dram_addr,
   input  wire logic [DW-1:0] dram_wdata,
   output var  logic [DW-1:0] dram_rdata,
   input  wire logic [DW-1:0] bad_mask
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   initial dram_rdata = '0;
   // data invert every cycle between reads, so a sample one cycle late sees the last word inverted
   always @(posedge aclk) begin
      if (dram_en && dram_we) mem[dram_addr] <= dram_wdata;
      if (dram_en && !dram_we) dram_rdata <= mem[dram_addr] ^
         ((dram_addr == AW'(BAD_ADDR)) ? bad_mask : '0);
      else dram_rdata <= ~dram_rdata;
   end
endmodule // etc_dram_model
`default_nettype wire

// >>> testbench/tb_etc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "etc_map.vh"
module tb_etc_ctrl;
   localparam DW = 16;
   localparam AW = 9;
   logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic          s_axi_rready, test_mode_enable, burn_in_select, march_start, tck_run;
   logic          controller_clock, controller_reset_n, pad_direction_select;
   logic [7:0]    s_axi_awaddr, s_axi_araddr, tester_address_bus;
   logic [31:0]   s_axi_wdata, d;
   logic [3:0]    s_axi_wstrb, tester_command_bus;
   logic [DW-1:0] tester_data_in, bad_mask;
   logic [1:0]    r;
   wire           s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire           irq, tester_data_oe, fail_flag, dram_en, dram_we, regulator_off;
   wire [1:0]     s_axi_bresp, s_axi_rresp;
   wire [31:0]    s_axi_rdata;
   wire [DW-1:0]  tester_data_out, dram_wdata, dram_rdata;
   wire [AW-1:0]  dram_addr;
   int            n_fail, checks, nr, nw, nf, s;
   etc_ctrl #(.DW(DW), .AW(AW)) DUT (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .irq, .test_mode_enable, .burn_in_select, .march_start, .controller_clock,
      .controller_reset_n, .tester_command_bus, .tester_address_bus, .pad_direction_select,
      .tester_data_in, .tester_data_out, .tester_data_oe, .fail_flag, .dram_en, .dram_we,
      .dram_addr, .dram_wdata, .dram_rdata, .regulator_off);
   etc_dram_model #(.DW(DW), .AW(AW)) u_dram (.aclk, .dram_en, .dram_we, .dram_addr,
      .dram_wdata, .dram_rdata, .bad_mask);
   // ------------------------------------------
   // clocks, counters and access tasks
   // ------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // tester clock stands low outside a command, a march or the after-abort check
   initial begin
      controller_clock = 1'b0;
      #5;
      forever #32 controller_clock = tck_run ? ~controller_clock : 1'b0;
   end
   always @(posedge aclk) begin
      if (dram_en === 1'b1 && dram_we === 1'b1) nw++;
      if (dram_en === 1'b1 && dram_we === 1'b0) nr++;
      if ($rose(fail_flag)) nf++;
   end
   task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic tc(input logic [3:0] c, input logic [7:0] a);
      @(posedge aclk);
      tester_command_bus <= c;
      tester_address_bus <= a;
      repeat (4) @(posedge aclk);
      tck_run = 1'b1;
      @(negedge controller_clock);
      tck_run = 1'b0;
      repeat (8) @(posedge aclk);
   endtask
   task automatic march(input logic b, input logic [DW-1:0] m, input int stop_at);
      int i;
      {nr, nw, nf} = '0;
      burn_in_select <= b;
      bad_mask <= m;
      tester_command_bus <= `ETC_CMD_PG_RUN;
      march_start <= 1'b1;
      repeat (6) @(posedge aclk);
      test_mode_enable <= 1'b1;
      tck_run = 1'b1;
      for (i = 0; i < 40000 && irq !== 1'b1; i++) begin
         @(posedge aclk);
         if (i == 1000) ck(32'(tester_data_oe), 0, "pad driven in march");
         if (i == stop_at - 500) tck_run = 1'b0;
         if (i == stop_at - 440) tck_run = 1'b1;
         if (i == stop_at) tester_command_bus <= `ETC_CMD_NOP;
      end
      tck_run = 1'b0;
      repeat (40) @(posedge aclk);
   endtask
   task automatic stop_run();
      test_mode_enable <= 1'b0;
      march_start <= 1'b0;
      tester_command_bus <= `ETC_CMD_NOP;
      wr(`ETC_REG_IRQ_CLR, 32'hF);
      ck(32'(irq), 0, "irq after clear");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ------------------------------------------
   // test sequence
   // ------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {test_mode_enable, burn_in_select, march_start, pad_direction_select, tck_run} = '0;
      {s_axi_awaddr, s_axi_araddr, tester_address_bus, s_axi_wdata, tester_data_in} = '0;
      {tester_command_bus, bad_mask} = '0;
      s_axi_wstrb = 4'hF;
      controller_reset_n = 1'b1;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`ETC_REG_CTRL);
      ck(d, 0, "ctrl reset");
      rd(8'h18);
      ck(d, 0, "unmapped read data");
      ck(32'(r), 32'(`ETC_RESP_SLVERR), "unmapped read");
      wr(8'h18, 32'h1);
      ck(32'(r), 32'(`ETC_RESP_SLVERR), "unmapped write");
      wr(`ETC_REG_IRQ_EN, 32'h5);
      rd(`ETC_REG_IRQ_EN);
      ck(d, 32'h5, "irq enable");
      $display("registers done");
      tester_data_in <= 16'hA5C3;
      pad_direction_select <= 1'b1;
      tc(`ETC_CMD_WRITE, 8'h00);
      ck(nw, 0, "access while disabled");
      test_mode_enable <= 1'b1;
      tc(`ETC_CMD_LD_ROW, 8'h01);
      tc(`ETC_CMD_LD_COL, 8'h23);
      ck(32'(dram_addr), 32'h123, "address load");
      tc(`ETC_CMD_WRITE, 8'h00);
      ck(nw, 1, "direct write");
      test_mode_enable <= 1'b0;
      wr(`ETC_REG_CTRL, 32'h1);
      tc(`ETC_CMD_READ, 8'h00);
      ck(32'(tester_data_out), 32'hA5C3, "direct read");
      ck(32'(tester_data_oe), 1, "pad out");
      pad_direction_select <= 1'b0;
      repeat (4) @(posedge aclk);
      ck(32'(tester_data_oe), 0, "pad in");
      wr(`ETC_REG_CTRL, 32'h0);
      $display("direct access done");
      march(1'b1, 16'h0008, -1);
      ck(nw, 1536, "march writes");
      ck(nr, 1536, "march reads");
      ck({30'(fail_flag), regulator_off}, 31'h3, "burn latch");
      rd(`ETC_REG_IRQ_STAT);
      ck(d, 32'h3, "done and fail");
      controller_reset_n <= 1'b0;
      repeat (6) @(posedge aclk);
      ck(32'(fail_flag), 0, "reset clears fail");
      controller_reset_n <= 1'b1;
      stop_run();
      $display("burn-in march done");
      tester_address_bus <= 8'hFF;
      tester_data_in <= 16'h1234;
      pad_direction_select <= 1'b1;
      march(1'b0, 16'h0008, -1);
      ck(nf, 3, "fail pulses");
      ck(nw, 1536, "march ignores pins");
      ck(32'(regulator_off), 0, "regulator on");
      stop_run();
      $display("fault march done");
      march(1'b0, 16'h0000, 2000);
      rd(`ETC_REG_IRQ_STAT);
      ck(d, 32'hC, "abort and slow flagged");
      ck(32'(nw < 512), 1, "abort early");
      s = nw + nr;
      tck_run = 1'b1;
      repeat (100) @(posedge aclk);
      tck_run = 1'b0;
      ck(nw + nr, s, "no access after abort");
      stop_run();
      $display("abort done");
      results();
   end
   initial begin
      #(100000 * 8);
      n_fail++;
      results();
   end
endmodule // tb_etc_ctrl
`default_nettype wire
